// ### fdp_decode.sv
// option and parameter decode with command sequencing for the floppy core
// What this block does
// (R1) fifo enable bit is active low; disabled is the reset value
// (R2) implied seek set: seek before read/write; clear: never seek
// (R3) last sector parameter ends the transfer on the current track
// (R4) perpendicular mode: gap option bit changes second gap length
// (R5) gap length parameter is third gap size, sync field excluded
// (R6) head select parameter picks disk side 0 or 1
// (R7) after loading head, wait settle interval before read/write
// (R8) unload head after release interval following execution end
// (R9) lock decides if soft reset restores fifo, threshold, precomp
// (R10) density bit one selects double density, zero single density
// (R11) multi-track treats both heads of a cylinder as one track
// (R12) multi-track continues from last head 0 sector to head 1 first
// (R13) command parameters stay unchanged until result phase ends
//
// Local design decisions: the plain strobed port and the register addresses.
module fdp_decode
  import fdp_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_UNIT_CYC,
  parameter int RELEASE_CYC = RELEASE_UNIT_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // drive sequencer
  input wire logic seek_done_i,
  input wire logic sector_done_i,
  output logic seek_req_o,
  output logic head_load_o,
  output logic sector_req_o,
  output logic [7:0] sector_o,
  output logic head_o,
  // decoded options
  output logic double_density_o,
  output logic fifo_en_o,
  output logic [3:0] fifo_thr_o,
  output logic [7:0] precomp_trk_o,
  output logic [7:0] gap3_len_o,
  output logic gap2_long_o,
  output logic busy_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic fifo_enable_low;
  logic implied_seek_enable;
  logic lock;
  logic [3:0] fifo_threshold;
  logic [7:0] precomp_start_track;
  logic [7:0] head_settle_delay;
  logic [7:0] head_release_delay;
  logic [4:0] options;
  logic [7:0] last_sector_number;
  logic [7:0] inter_sector_gap_length;
  logic [7:0] first_sector;
  fdp_state_e state;
  logic [7:0] cur_sector;
  logic cur_head;
  logic soft_rst;
  logic start_cmd;
  logic ack_cmd;
  logic busy;
  logic at_last;
  logic wrap;
  fdp_tmr_if settle_t();
  fdp_tmr_if release_t();

  assign busy = (state != ST_IDLE);
  assign soft_rst = wr_i && addr_i == OFS_CTRL && wdata_i[CTL_SOFT_RST];
  assign start_cmd = wr_i && addr_i == OFS_CTRL && wdata_i[CTL_START] && !busy && !soft_rst;
  assign ack_cmd = wr_i && addr_i == OFS_CTRL && wdata_i[CTL_ACK];
  assign at_last = (cur_sector == last_sector_number); // see R3
  assign wrap = options[OPT_MULTI] && !cur_head; // see R11

  // ----------------------------------------
  // configuration, locked fields
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      fifo_enable_low <= RST_FIFO_LOW; // see R1
      fifo_threshold <= RST_THR;
      precomp_start_track <= RST_PRECOMP;
      lock <= 1'b0;
    end
    else if (soft_rst)
    begin
      // lock itself survives a soft reset
      if (!lock)
      begin
        fifo_enable_low <= RST_FIFO_LOW; // see R9
        fifo_threshold <= RST_THR;
        precomp_start_track <= RST_PRECOMP;
      end
    end
    else if (wr_i && !busy && addr_i == OFS_CONFIG)
    begin
      fifo_enable_low <= wdata_i[CFG_FIFO_LOW];
      fifo_threshold <= wdata_i[CFG_THR_LO +: 4];
      lock <= wdata_i[CFG_LOCK];
    end
    else if (wr_i && !busy && addr_i == OFS_PRECOMP)
      precomp_start_track <= wdata_i;
  end

  // ----------------------------------------
  // command parameters, frozen while busy
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i || soft_rst)
    begin
      implied_seek_enable <= 1'b0;
      head_settle_delay <= RST_BYTE;
      head_release_delay <= RST_BYTE;
      options <= 5'h00;
      last_sector_number <= RST_BYTE;
      inter_sector_gap_length <= RST_BYTE;
      first_sector <= FIRST_SECTOR_NUM;
    end
    else if (wr_i && !busy) // see R13
    begin
      case (addr_i)
        OFS_CONFIG: implied_seek_enable <= wdata_i[CFG_SEEK];
        OFS_SETTLE: head_settle_delay <= wdata_i;
        OFS_RELEASE: head_release_delay <= wdata_i;
        OFS_OPTIONS: options <= wdata_i[4:0];
        OFS_LAST_SECTOR: last_sector_number <= wdata_i;
        OFS_GAP_LEN: inter_sector_gap_length <= wdata_i;
        OFS_FIRST_SECTOR: first_sector <= wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // head timers
  // ----------------------------------------
  assign settle_t.start = (state == ST_HLOAD) && !head_load_o;
  assign settle_t.cancel = soft_rst;
  assign settle_t.units = head_settle_delay;
  assign release_t.start = (state == ST_XFER) && sector_done_i && at_last && !wrap;
  assign release_t.cancel = start_cmd || soft_rst;
  assign release_t.units = head_release_delay;

  fdp_timer #(.UNIT_CYC(SETTLE_CYC)) u_settle (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .t(settle_t.timer)
  );

  fdp_timer #(.UNIT_CYC(RELEASE_CYC)) u_release (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .t(release_t.timer)
  );

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i || soft_rst)
    begin
      state <= ST_IDLE;
      seek_req_o <= 1'b0;
      head_load_o <= 1'b0;
      sector_req_o <= 1'b0;
      cur_sector <= FIRST_SECTOR_NUM;
      cur_head <= 1'b0;
    end
    else
    begin
      sector_req_o <= 1'b0;
      if (release_t.done && state != ST_HLOAD)
        head_load_o <= 1'b0; // see R8
      case (state)
        ST_IDLE:
          if (start_cmd)
          begin
            cur_sector <= first_sector;
            cur_head <= options[OPT_HEAD]; // see R6
            if (implied_seek_enable) // see R2
            begin
              seek_req_o <= 1'b1;
              state <= ST_SEEK;
            end
            else
              state <= ST_HLOAD;
          end
        ST_SEEK:
          if (seek_done_i)
          begin
            seek_req_o <= 1'b0;
            state <= ST_HLOAD;
          end
        ST_HLOAD:
          // an already loaded head needs no second settle
          if (head_load_o)
          begin
            sector_req_o <= 1'b1;
            state <= ST_XFER;
          end
          else
          begin
            head_load_o <= 1'b1;
            state <= ST_SETTLE;
          end
        ST_SETTLE:
          if (settle_t.done) // see R7
          begin
            sector_req_o <= 1'b1;
            state <= ST_XFER;
          end
        ST_XFER:
          if (sector_done_i)
          begin
            if (!at_last)
            begin
              cur_sector <= cur_sector + 8'h01;
              sector_req_o <= 1'b1;
            end
            else if (wrap)
            begin
              cur_head <= 1'b1; // see R12
              cur_sector <= FIRST_SECTOR_NUM;
              sector_req_o <= 1'b1;
            end
            else
              state <= ST_RESULT; // see R3
          end
        ST_RESULT:
          if (ack_cmd)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // registered decode outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      fifo_en_o <= 1'b0;
      fifo_thr_o <= RST_THR;
      precomp_trk_o <= RST_PRECOMP;
      double_density_o <= 1'b0;
      gap3_len_o <= RST_BYTE;
      gap2_long_o <= 1'b0;
      sector_o <= FIRST_SECTOR_NUM;
      head_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      fifo_en_o <= !fifo_enable_low; // see R1
      fifo_thr_o <= fifo_threshold;
      precomp_trk_o <= precomp_start_track;
      double_density_o <= options[OPT_DD]; // see R10
      // sync field is added by the sequencer, not counted here
      gap3_len_o <= inter_sector_gap_length; // see R5
      gap2_long_o <= options[OPT_PERP] && options[OPT_GAP]; // see R4
      sector_o <= cur_sector;
      head_o <= cur_head;
      busy_o <= busy;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rdata_o <= RST_BYTE;
    else if (rd_i)
    begin
      case (addr_i)
        OFS_CONFIG: rdata_o <= {fifo_threshold, 1'b0, lock, implied_seek_enable,
                                fifo_enable_low};
        OFS_PRECOMP: rdata_o <= precomp_start_track;
        OFS_SETTLE: rdata_o <= head_settle_delay;
        OFS_RELEASE: rdata_o <= head_release_delay;
        OFS_OPTIONS: rdata_o <= {3'h0, options};
        OFS_LAST_SECTOR: rdata_o <= last_sector_number;
        OFS_GAP_LEN: rdata_o <= inter_sector_gap_length;
        OFS_FIRST_SECTOR: rdata_o <= first_sector;
        OFS_STATUS: rdata_o <= {2'h0, state == ST_RESULT, cur_head, 1'b0,
                                seek_req_o, head_load_o, busy};
        OFS_CUR_SECTOR: rdata_o <= cur_sector;
        default: rdata_o <= RST_BYTE;
      endcase
    end
    else
      rdata_o <= RST_BYTE;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_last_h0;
    state == ST_XFER && sector_done_i && at_last && wrap;
  endsequence
  sequence s_track_end;
    state == ST_XFER && sector_done_i && at_last && !wrap;
  endsequence

  AST_FIFO_POL: assert property (##1 fifo_en_o == !$past(fifo_enable_low)) // see R1
    else $error("fifo enable polarity wrong");
  AST_SEEK_ON: assert property (start_cmd && implied_seek_enable |=> seek_req_o) // see R2
    else $error("implied seek not requested");
  AST_SEEK_OFF: assert property (start_cmd && !implied_seek_enable |=> !seek_req_o[*2]) // see R2
    else $error("seek without implied seek");
  AST_TRACK_END: assert property (s_track_end |=> state == ST_RESULT) // see R3
    else $error("transfer did not stop at last sector");
  AST_GAP2: assert property (##1 gap2_long_o == $past(options[OPT_PERP] && options[OPT_GAP])) // see R4
    else $error("second gap option wrong");
  AST_GAP3: assert property (##1 gap3_len_o == $past(inter_sector_gap_length)) // see R5
    else $error("third gap length wrong");
  AST_HEAD: assert property (start_cmd |=> cur_head == $past(options[OPT_HEAD])) // see R6
    else $error("head select not taken");
  AST_SETTLE: assert property (state == ST_SETTLE && !settle_t.done |=> state != ST_XFER) // see R7
    else $error("transfer before head settle");
  AST_UNLOAD: assert property (release_t.done && state != ST_HLOAD |=> !head_load_o) // see R8
    else $error("head not unloaded");
  AST_LOCK: assert property (soft_rst && lock |=> $stable(fifo_enable_low) && $stable(fifo_threshold)
                             && $stable(precomp_start_track)) // see R9
    else $error("locked setting changed by soft reset");
  AST_DENSITY: assert property (##1 double_density_o == $past(options[OPT_DD])) // see R10
    else $error("density select wrong");
  AST_MULTI_WRAP: assert property (s_last_h0 |=> cur_head && cur_sector == FIRST_SECTOR_NUM
                                && state == ST_XFER ##1 sector_o == FIRST_SECTOR_NUM) // see R12
    else $error("multi-track did not continue on head 1");
  AST_HOLD: assert property (busy && !soft_rst |=> $stable(options) && $stable(last_sector_number)) // see R13
    else $error("parameters changed during command");
endmodule

// ### fdp_pkg.sv
// constants and types shared by the floppy command parameter block
package fdp_pkg;
  // ----------------------------------------
  // register port
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_PRECOMP = 4'h1;
  localparam logic [3:0] OFS_SETTLE = 4'h2;
  localparam logic [3:0] OFS_RELEASE = 4'h3;
  localparam logic [3:0] OFS_OPTIONS = 4'h4;
  localparam logic [3:0] OFS_LAST_SECTOR = 4'h5;
  localparam logic [3:0] OFS_GAP_LEN = 4'h6;
  localparam logic [3:0] OFS_FIRST_SECTOR = 4'h7;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h9;
  localparam logic [3:0] OFS_CUR_SECTOR = 4'hA;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_FIFO_LOW = 0;
  localparam int CFG_SEEK = 1;
  localparam int CFG_LOCK = 2;
  localparam int CFG_THR_LO = 4;
  localparam int OPT_HEAD = 0;
  localparam int OPT_DD = 1;
  localparam int OPT_MULTI = 2;
  localparam int OPT_PERP = 3;
  localparam int OPT_GAP = 4;
  localparam int CTL_START = 0;
  localparam int CTL_SOFT_RST = 1;
  localparam int CTL_ACK = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_FIFO_LOW = 1'b1;
  localparam logic [3:0] RST_THR = 4'h0;
  localparam logic [7:0] RST_PRECOMP = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] FIRST_SECTOR_NUM = 8'h01;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int SETTLE_UNIT_MS = 1;
  localparam int RELEASE_UNIT_MS = 16;
  localparam int SETTLE_UNIT_CYC = SETTLE_UNIT_MS * (CLK_HZ / 1000);
  localparam int RELEASE_UNIT_CYC = RELEASE_UNIT_MS * (CLK_HZ / 1000);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_HLOAD, ST_SETTLE, ST_XFER, ST_RESULT
  } fdp_state_e;
endpackage

// ### fdp_tmr_if.sv
// handshake between the sequencer and one interval timer
interface fdp_tmr_if;
  logic start;
  logic cancel;
  logic [7:0] units;
  logic done;
  modport owner (output start, output cancel, output units, input done);
  modport timer (input start, input cancel, input units, output done);
endinterface

// ### fdp_timer.sv
// interval timer counting whole units of a fixed cycle length
module fdp_timer
  import fdp_pkg::*;
#(
  parameter int UNIT_CYC = 1
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control
  fdp_tmr_if.timer t
);
  logic run;
  logic [7:0] units_left;
  logic [31:0] pre;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || t.cancel)
    begin
      run <= 1'b0;
      t.done <= 1'b0;
      units_left <= 8'h00;
      pre <= 32'h0;
    end
    else
    begin
      t.done <= 1'b0;
      if (t.start)
      begin
        run <= 1'b1;
        units_left <= t.units;
        pre <= 32'(UNIT_CYC - 1);
      end
      else if (run)
      begin
        if (pre != 32'h0)
          pre <= pre - 32'h1;
        else if (units_left == 8'h00)
        begin
          run <= 1'b0;
          t.done <= 1'b1;
        end
        else
        begin
          units_left <= units_left - 8'h01;
          pre <= 32'(UNIT_CYC - 1);
        end
      end
    end
  end
endmodule

// ### fdp_seq_model.sv
// drive sequencer stand-in answering seek and sector requests
module fdp_seq_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // sequencer link
  input wire logic seek_req_i,
  input wire logic sector_req_i,
  input wire logic [7:0] sector_i,
  input wire logic head_i,
  input wire logic slow_i,
  output logic seek_done_o = 1'b0,
  output logic sector_done_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // log holds {head, sector[6:0]}: test sectors stay below 128
  logic [7:0] log_q[$];
  int seeks = 0;
  int cnt = 0;
  int sk = 0;
  logic cap = 1'b0;

  always @(posedge clk_i)
  begin
    seek_done_o <= 1'b0;
    sector_done_o <= 1'b0;
    cap <= sector_req_i && !srst_i;
    if (srst_i)
      cnt <= 0;
    else if (cap)
    begin
      log_q.push_back({head_i, sector_i[6:0]});
      cnt <= slow_i ? 6 : 1;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      cnt <= 0;
      sector_done_o <= 1'b1;
    end
    // seek takes a few cycles so the request is seen standing
    if (srst_i || !seek_req_i || seek_done_o)
      sk <= 0;
    else if (sk == 3)
    begin
      sk <= 0;
      seek_done_o <= 1'b1;
      seeks <= seeks + 1;
    end
    else
      sk <= sk + 1;
  end
endmodule

// ### floppy_command_parameter_decode_tb.sv
// self-checking bench for the floppy command parameter decode
module floppy_command_parameter_decode_tb
  import fdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SET_C = 4;
  localparam int REL_C = 8;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} fdp_row_s;
  fdp_row_s rows[8] = '{'{OFS_CONFIG, 8'h00, 8'h08}, '{OFS_CONFIG, 8'h51, 8'h50},
    '{OFS_OPTIONS, 8'h02, 8'h54}, '{OFS_OPTIONS, 8'h08, 8'h50},
    '{OFS_OPTIONS, 8'h18, 8'h52}, '{OFS_OPTIONS, 8'h10, 8'h50},
    '{OFS_PRECOMP, 8'h2C, 8'h2C}, '{OFS_GAP_LEN, 8'h1B, 8'h1B}};
  logic [7:0] multi_exp[4] = '{8'h01, 8'h02, 8'h81, 8'h82};
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic slow = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic seek_done_i, sector_done_i, seek_req_o, head_load_o, sector_req_o, head_o;
  logic double_density_o, fifo_en_o, gap2_long_o, busy_o;
  logic [7:0] sector_o, precomp_trk_o, gap3_len_o;
  logic [3:0] fifo_thr_o;
  int mismatches = 0;
  int tests_run = 0;

  always #10 clk_i = ~clk_i;

  fdp_decode #(.SETTLE_CYC(SET_C), .RELEASE_CYC(REL_C)) dut (.clk_i, .srst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .seek_done_i, .sector_done_i, .seek_req_o,
    .head_load_o, .sector_req_o, .sector_o, .head_o, .double_density_o, .fifo_en_o, .fifo_thr_o,
    .precomp_trk_o, .gap3_len_o, .gap2_long_o, .busy_o);

  fdp_seq_model sq (.clk_i, .srst_i, .seek_req_i(seek_req_o), .sector_req_i(sector_req_o),
    .sector_i(sector_o), .head_i(head_o), .slow_i(slow), .seek_done_o(seek_done_i),
    .sector_done_o(sector_done_i));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic wait_st(input int b, input logic v);
    logic [7:0] s;
    for (int i = 0; i < 300; i++)
    begin
      rd(OFS_STATUS, s);
      if (s[b] === v)
        return;
    end
    chk("status bit", {7'h0, v}, {7'h0, s[b]});
  endtask

  function automatic logic [7:0] view(input logic [3:0] a);
    if (a == OFS_PRECOMP)
      return precomp_trk_o;
    if (a == OFS_GAP_LEN)
      return gap3_len_o;
    return {fifo_thr_o, fifo_en_o, double_density_o, gap2_long_o, 1'b0};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    logic [7:0] v;
    int n;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    #1 chk("fifo_en", 8'h00, {7'h0, fifo_en_o});
    chk("sector", FIRST_SECTOR_NUM, sector_o);
    rd(OFS_CONFIG, v);
    chk("config", 8'h01, v);
    rd(4'hF, v);
    chk("unmapped", 8'h00, v);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      repeat (2) @(posedge clk_i);
      #1 chk("row", rows[i].e, view(rows[i].a));
    end
    $display("option table done");
    wr(OFS_CONFIG, 8'h03);
    wr(OFS_SETTLE, 8'h00);
    wr(OFS_RELEASE, 8'h00);
    wr(OFS_OPTIONS, 8'h06);
    wr(OFS_FIRST_SECTOR, 8'h01);
    wr(OFS_LAST_SECTOR, 8'h02);
    wr(OFS_CTRL, 8'h01);
    wr(OFS_GAP_LEN, 8'h40);
    n = 0;
    for (int i = 0; i < 500 && !sector_req_o; i++)
    begin
      @(posedge clk_i);
      #1 n += head_load_o;
    end
    chk("settle", 8'h01, {7'h0, n >= SET_C});
    wait_st(5, 1'b1);
    chk("head held", 8'h01, {7'h0, head_load_o});
    chk("seeks", 8'h01, 8'(sq.seeks));
    chk("count", 8'h04, 8'(sq.log_q.size()));
    foreach (multi_exp[i])
      chk("multi sector", multi_exp[i], sq.log_q[i]);
    chk("gap frozen", 8'h1B, gap3_len_o);
    repeat (2 * REL_C + 4) @(posedge clk_i);
    #1 chk("unloaded", 8'h00, {7'h0, head_load_o});
    wr(OFS_CTRL, 8'h04);
    $display("multi track test done");
    slow <= 1'b1;
    sq.log_q.delete();
    wr(OFS_CONFIG, 8'h01);
    wr(OFS_OPTIONS, 8'h03);
    wr(OFS_FIRST_SECTOR, 8'h03);
    wr(OFS_LAST_SECTOR, 8'h03);
    wr(OFS_CTRL, 8'h01);
    wait_st(5, 1'b1);
    chk("no seek", 8'h01, 8'(sq.seeks));
    chk("count", 8'h01, 8'(sq.log_q.size()));
    chk("head 1", 8'h83, sq.log_q[0]);
    chk("busy", 8'h01, {7'h0, busy_o});
    // result phase, head 1, head still loaded, no seek
    rd(OFS_STATUS, v);
    chk("status", 8'h33, v);
    rd(OFS_CUR_SECTOR, v);
    chk("cur sector", 8'h03, v);
    wr(OFS_CTRL, 8'h04);
    $display("single sector test done");
    wr(OFS_CONFIG, 8'h54);
    wr(OFS_CTRL, 8'h02);
    repeat (2) @(posedge clk_i);
    #1 chk("locked", 8'h0B, {3'h0, fifo_thr_o, fifo_en_o});
    chk("locked precomp", 8'h2C, precomp_trk_o);
    wr(OFS_CONFIG, 8'h50);
    wr(OFS_CTRL, 8'h02);
    repeat (2) @(posedge clk_i);
    #1 chk("unlocked", 8'h00, {3'h0, fifo_thr_o, fifo_en_o});
    chk("unlocked precomp", 8'h00, precomp_trk_o);
    $display("soft reset test done");
    wr(OFS_CTRL, 8'h01);
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    #1 chk("reset busy", 8'h00, {6'h0, busy_o, head_load_o});
    $display("mid command reset test done");
    summarize();
  end

  initial
  begin
    // the whole sequence needs under two hundred cycles
    repeat (20000) @(posedge clk_i);
    mismatches++;
    summarize();
  end
endmodule
